// ===== src/serializer_clock_mode_select.sv
// Serializer end: clocking mode, line rate, bandwidth limit and sensor clock.
//
// Overview of operation
// - Forward reference from mode source, rate multiple.
// - Capture strap mode on power-down release rise.
// - Synchronous: back-channel reference, line x160, CSI x128.
// - Synchronous: recovered clock also feeds sensor clock.
// - External: divider 000 gives x80, 001 gives x40.
// - Sensor keeps CSI under x64 or x32 limit.
// - External mode: CSI may run on reference.
// - Internal: oscillator reference, select bit sets rate.
// - Internal mode: system supplies sensor its clock.
// - External modes: partner drives external reference input.
// - Sensor clock = line / divider x M/N.
// - Parallel compat: x28 line, x20 or x18 CSI.
// - Parallel compat: CSI synchronous to external reference.
// - Mode field always shows current mode.
// - Mode field read-only unless override bit set.
// - Code 101 reads and selects parallel compat mode.
// - Format register picks RAW10 or RAW12 output.
// - Parallel video configuration register selects carriage.
// - Match enable passes packets of programmed type.
// - Mode codes 0, 2, 3 and 5.
// - Sensor clock off in internal mode.
// - M, N, divider held at 0x06 and 0x07.
`timescale 1ns/1ns
module serializer_clock_mode_select #(
  parameter logic [31:0] OSC_FULL_KHZ = 32'h0000_C350, // Oscillator nominal, full rate.
  parameter logic [31:0] OSC_HALF_KHZ = 32'h0000_61A8, // Oscillator nominal, half rate.
  parameter int RELOCK_CYCLES = clock_mode_pkg::RELOCK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_down_release,
  input wire logic [2:0] strap_mode,
  input wire logic frame_active,
  input wire logic pkt_valid,
  input wire logic [5:0] pkt_dt,
  output logic pkt_pass,
  output logic csi_sync_to_ref,
  output logic sensor_clock_enable,
  output logic [31:0] sensor_clock_khz,
  output logic [7:0] parallel_video_config,
  output logic raw12_select,
  clock_mode_if.device link
);

  // Lock sequencing states.
  typedef enum logic [1:0] {ST_RUN, ST_WAIT_FRAME, ST_RELOCK} lock_state_e;
  lock_state_e state_q; // Lock sequencer state.
  logic [2:0] mode_q; // Mode in use.
  logic [2:0] pend_mode_q; // Mode written by software, not yet applied.
  logic override_q; // Software override of the mode field.
  logic raw12_q; // Parallel output format.
  logic osc_full_q; // Oscillator rate select.
  logic [2:0] refdiv_q; // Reference input divider.
  logic [1:0] hs_code_q; // High-speed divider code.
  logic [4:0] m_q; // Sensor clock multiplier.
  logic [7:0] n_q; // Sensor clock divider.
  logic [7:0] pv_cfg_q; // Parallel video configuration.
  logic [5:0] pv_dt_q; // Data type to match.
  logic pdr_q; // Previous power-down release level.
  logic [15:0] lock_cnt_q; // Relock countdown.
  logic ack_q; // Register acknowledge.
  logic [7:0] rdata_q; // Register read data.
  logic [31:0] line_q; // Registered line rate.
  logic [31:0] csi_q; // Registered bandwidth limit.
  logic [31:0] sclk_q; // Registered sensor clock figure.
  logic pass_q; // Packet filter verdict.
  logic [31:0] ref_khz; // Selected reference frequency.
  logic [7:0] line_mul; // Line rate multiplier.
  logic [7:0] csi_mul; // Bandwidth multiplier.
  logic sclk_on; // Sensor clock allowed in this mode.
  logic [7:0] rd_mux; // Read data before the register.
  logic wr_stb; // One write per request.
  logic pdr_rise; // Power-down release rising edge.

  assign wr_stb = link.reg_valid && link.reg_write && !ack_q;
  assign pdr_rise = power_down_release && !pdr_q;
  // Reference and multipliers follow the mode in use.
  always_comb begin
    ref_khz = 32'h0000_0000;
    line_mul = 8'h00;
    csi_mul = 8'h00;
    sclk_on = 1'b0;
    case (mode_q)
      clock_mode_pkg::MODE_SYNC: begin
        ref_khz = link.backchannel_ref_khz;
        line_mul = clock_mode_pkg::MUL_SYNC_LINE;
        csi_mul = clock_mode_pkg::MUL_SYNC_CSI;
        sclk_on = 1'b1;
      end
      clock_mode_pkg::MODE_EXT: begin
        ref_khz = link.external_reference_input_khz;
        sclk_on = 1'b1;
        if (refdiv_q == clock_mode_pkg::REFDIV_BY2) begin
          line_mul = clock_mode_pkg::MUL_EXT2_LINE;
          csi_mul = clock_mode_pkg::MUL_EXT2_CSI;
        end else begin
          // Codes other than the two known ones fall back to the undivided setting.
          line_mul = clock_mode_pkg::MUL_EXT1_LINE;
          csi_mul = clock_mode_pkg::MUL_EXT1_CSI;
        end
      end
      clock_mode_pkg::MODE_INT: begin
        ref_khz = osc_full_q ? OSC_FULL_KHZ : OSC_HALF_KHZ;
        line_mul = clock_mode_pkg::MUL_EXT1_LINE;
        csi_mul = clock_mode_pkg::MUL_EXT1_CSI;
        sclk_on = 1'b0;
      end
      clock_mode_pkg::MODE_PVC: begin
        ref_khz = link.external_reference_input_khz;
        line_mul = clock_mode_pkg::MUL_PVC_LINE;
        csi_mul = raw12_q ? clock_mode_pkg::MUL_PVC_RAW12
                          : clock_mode_pkg::MUL_PVC_RAW10;
        sclk_on = 1'b1;
      end
      default: sclk_on = 1'b0; // Unknown codes leave the link without a reference.
    endcase
  end

  // Line rate and limit are registered; they only move when the mode, reference, divider, oscillator or format setting does.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_q <= 32'h0000_0000;
      csi_q <= 32'h0000_0000;
    end else begin
      line_q <= 32'(ref_khz * {24'h00_0000, line_mul});
      csi_q <= 32'(ref_khz * {24'h00_0000, csi_mul});
    end
  end
  // Strap capture, override queueing and relock. Override mode changes wait for frame gaps; strap capture does not.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_RELOCK;
      mode_q <= clock_mode_pkg::RST_MODE;
      pend_mode_q <= clock_mode_pkg::RST_MODE;
      lock_cnt_q <= 16'(RELOCK_CYCLES);
      pdr_q <= 1'b0;
    end else begin
      pdr_q <= power_down_release;
      if (pdr_rise) begin
        mode_q <= strap_mode;
        state_q <= ST_RELOCK;
        lock_cnt_q <= 16'(RELOCK_CYCLES);
      end else begin
        case (state_q)
          ST_RUN: begin
            if (wr_stb && link.reg_addr == clock_mode_pkg::ADDR_MODE && override_q) begin
              pend_mode_q <= link.reg_wdata[2:0];
              state_q <= ST_WAIT_FRAME;
            end
          end
          ST_WAIT_FRAME: begin
            // Never apply the pending override mode while a frame is on the wire.
            if (!frame_active) begin
              mode_q <= pend_mode_q;
              lock_cnt_q <= 16'(RELOCK_CYCLES);
              state_q <= ST_RELOCK;
            end
          end
          ST_RELOCK: begin
            if (lock_cnt_q <= 16'h0001) begin
              state_q <= ST_RUN;
              lock_cnt_q <= 16'h0000;
            end else begin
              lock_cnt_q <= lock_cnt_q - 16'h0001;
            end
          end
          default: state_q <= ST_RUN;
        endcase
      end
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      override_q <= 1'b0;
      raw12_q <= 1'b0;
      osc_full_q <= 1'b0;
      refdiv_q <= clock_mode_pkg::RST_REFDIV;
      hs_code_q <= clock_mode_pkg::RST_HS_CODE;
      m_q <= clock_mode_pkg::RST_M;
      n_q <= clock_mode_pkg::RST_N;
      pv_cfg_q <= clock_mode_pkg::RST_PV_CFG;
      pv_dt_q <= clock_mode_pkg::RST_PV_DT;
    end else if (wr_stb) begin
      if (link.reg_addr == clock_mode_pkg::ADDR_MODE) begin
        override_q <= link.reg_wdata[clock_mode_pkg::MODE_OVR_BIT];
      end else if (link.reg_addr == clock_mode_pkg::ADDR_FORMAT) begin
        raw12_q <= link.reg_wdata[clock_mode_pkg::FORMAT_RAW12_BIT];
      end else if (link.reg_addr == clock_mode_pkg::ADDR_REFCFG) begin
        osc_full_q <= link.reg_wdata[clock_mode_pkg::OSC_FULL_BIT];
        refdiv_q <= link.reg_wdata[2:0];
      end else if (link.reg_addr == clock_mode_pkg::ADDR_SCLK_MDIV) begin
        m_q <= link.reg_wdata[7:3];
        hs_code_q <= link.reg_wdata[1:0];
      end else if (link.reg_addr == clock_mode_pkg::ADDR_SCLK_N) begin
        n_q <= link.reg_wdata;
      end else if (link.reg_addr == clock_mode_pkg::ADDR_PV_CFG) begin
        pv_cfg_q <= link.reg_wdata;
      end else if (link.reg_addr == clock_mode_pkg::ADDR_PV_DT) begin
        pv_dt_q <= link.reg_wdata[5:0];
      end
    end
  end
  // Read mux; unmapped offsets read zero.
  always_comb begin
    rd_mux = 8'h00;
    if (link.reg_addr == clock_mode_pkg::ADDR_MODE) begin
      rd_mux = {3'h0, override_q, 1'b0, mode_q};
    end else if (link.reg_addr == clock_mode_pkg::ADDR_FORMAT) begin
      rd_mux = {7'h00, raw12_q};
    end else if (link.reg_addr == clock_mode_pkg::ADDR_REFCFG) begin
      rd_mux = {4'h0, osc_full_q, refdiv_q};
    end else if (link.reg_addr == clock_mode_pkg::ADDR_SCLK_MDIV) begin
      rd_mux = {m_q, 1'b0, hs_code_q};
    end else if (link.reg_addr == clock_mode_pkg::ADDR_SCLK_N) begin
      rd_mux = n_q;
    end else if (link.reg_addr == clock_mode_pkg::ADDR_PV_CFG) begin
      rd_mux = pv_cfg_q;
    end else if (link.reg_addr == clock_mode_pkg::ADDR_PV_DT) begin
      rd_mux = {2'h0, pv_dt_q};
    end
  end
  // One acknowledge per request, one cycle after it is seen.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q <= link.reg_valid && !ack_q;
      rdata_q <= rd_mux;
    end
  end
  // Packet filter: a type match passes regardless of the RAW format.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pass_q <= 1'b0;
    end else begin
      pass_q <= pkt_valid && pv_cfg_q[clock_mode_pkg::DT_MATCH_EN_BIT]
                && pkt_dt == pv_dt_q;
    end
  end

  // Sensor clock figure line * M / (divider * N), one cycle behind the line rate.
  logic [clock_mode_pkg::DIV_W-1:0] sclk_num; // Line rate times M.
  logic [clock_mode_pkg::DIV_W-1:0] sclk_den; // High-speed divider times N.
  assign sclk_num = 40'({8'h00, line_q}) * 40'(m_q);
  assign sclk_den = 40'({3'h0, clock_mode_pkg::HS_DIV_BASE} << hs_code_q) * 40'(n_q);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_q <= 32'h0000_0000;
    end else begin
      // A zero N gives no meaningful clock, so report zero rather than divide by zero.
      sclk_q <= (sclk_den == '0) ? 32'h0000_0000 : 32'(sclk_num / sclk_den);
    end
  end
  assign link.reg_ack = ack_q;
  assign link.reg_rdata = rdata_q;
  assign link.active_mode = mode_q;
  assign link.link_locked = (state_q != ST_RELOCK);
  assign link.forward_line_rate_khz = line_q;
  assign link.csi_limit_khz = csi_q;
  assign sensor_clock_enable = sclk_on && (state_q != ST_RELOCK);
  assign sensor_clock_khz = sclk_on ? sclk_q : 32'h0000_0000;
  assign csi_sync_to_ref = (mode_q == clock_mode_pkg::MODE_EXT)
                           || (mode_q == clock_mode_pkg::MODE_PVC);
  assign pkt_pass = pass_q;
  assign parallel_video_config = pv_cfg_q;
  assign raw12_select = raw12_q;

endmodule : serializer_clock_mode_select

// ===== src/clock_mode_pkg.sv
// Shared constants for the serializer clocking mode selection block.
package clock_mode_pkg;

  // Mode codes held in the mode field of the mode register.
  localparam logic [2:0] MODE_SYNC = 3'h0;
  localparam logic [2:0] MODE_EXT = 3'h2;
  localparam logic [2:0] MODE_INT = 3'h3;
  localparam logic [2:0] MODE_PVC = 3'h5;

  // Register offsets.
  localparam logic [7:0] ADDR_MODE = 8'h03;
  localparam logic [7:0] ADDR_FORMAT = 8'h04;
  localparam logic [7:0] ADDR_REFCFG = 8'h05;
  localparam logic [7:0] ADDR_SCLK_MDIV = 8'h06;
  localparam logic [7:0] ADDR_SCLK_N = 8'h07;
  localparam logic [7:0] ADDR_PV_CFG = 8'h10;
  localparam logic [7:0] ADDR_PV_DT = 8'h11;

  // Field positions.
  localparam int MODE_OVR_BIT = 4;
  localparam int FORMAT_RAW12_BIT = 0;
  localparam int OSC_FULL_BIT = 3;
  localparam int DT_MATCH_EN_BIT = 7;

  // Reset values.
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [2:0] RST_REFDIV = 3'h0;
  localparam logic [1:0] RST_HS_CODE = 2'h0;
  localparam logic [4:0] RST_M = 5'h01;
  localparam logic [7:0] RST_N = 8'h01;
  localparam logic [7:0] RST_PV_CFG = 8'h00;
  localparam logic [5:0] RST_PV_DT = 6'h00;

  // Reference input divider codes.
  localparam logic [2:0] REFDIV_BY1 = 3'h0;
  localparam logic [2:0] REFDIV_BY2 = 3'h1;

  // Line rate and bandwidth multipliers of the reference frequency.
  localparam logic [7:0] MUL_SYNC_LINE = 8'hA0;
  localparam logic [7:0] MUL_SYNC_CSI = 8'h80;
  localparam logic [7:0] MUL_EXT1_LINE = 8'h50;
  localparam logic [7:0] MUL_EXT1_CSI = 8'h40;
  localparam logic [7:0] MUL_EXT2_LINE = 8'h28;
  localparam logic [7:0] MUL_EXT2_CSI = 8'h20;
  localparam logic [7:0] MUL_PVC_LINE = 8'h1C;
  localparam logic [7:0] MUL_PVC_RAW10 = 8'h14;
  localparam logic [7:0] MUL_PVC_RAW12 = 8'h12;

  // High-speed divider base value, shifted left by the divider code.
  localparam logic [4:0] HS_DIV_BASE = 5'h04;

  // Relock time after a mode change.
  localparam int CLK_PERIOD_NS = 4;
  localparam int RELOCK_NS = 1000;
  localparam int RELOCK_CYCLES = (RELOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Width of the operands of the sensor clock division.
  localparam int DIV_W = 40;

endpackage : clock_mode_pkg

// ===== src/clock_mode_if.sv
// Link between the serializer clock block and its companion party.
`timescale 1ns/1ns
interface clock_mode_if;
  logic reg_valid; // Register request held until acknowledged.
  logic reg_write; // High for a write.
  logic [7:0] reg_addr; // Register offset.
  logic [7:0] reg_wdata; // Write data.
  logic reg_ack; // One-cycle acknowledge.
  logic [7:0] reg_rdata; // Read data, valid with the acknowledge.
  logic [31:0] backchannel_ref_khz; // Recovered back-channel reference.
  logic [31:0] external_reference_input_khz; // Clock on the external input.
  logic [2:0] active_mode; // Mode now in use.
  logic link_locked; // Forward link running on its reference.
  logic [31:0] forward_line_rate_khz; // Forward line rate.
  logic [31:0] csi_limit_khz; // Highest allowed sensor throughput.

  modport device (input reg_valid, reg_write, reg_addr, reg_wdata, backchannel_ref_khz,
    external_reference_input_khz, output reg_ack, reg_rdata, active_mode, link_locked,
    forward_line_rate_khz, csi_limit_khz);
  modport partner (output reg_valid, reg_write, reg_addr, reg_wdata, backchannel_ref_khz,
    external_reference_input_khz, input reg_ack, reg_rdata, active_mode, link_locked,
    forward_line_rate_khz, csi_limit_khz);
endinterface : clock_mode_if

// ===== src/clock_mode_partner.sv
// Companion end: register requests, reference supply and CSI throughput cap.
`timescale 1ns/1ns
module clock_mode_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  input wire logic [31:0] local_ref_khz,
  input wire logic [31:0] recovered_ref_khz,
  input wire logic [31:0] csi_request_khz,
  output logic [31:0] csi_granted_khz,
  output logic sensor_own_ref_enable,
  output logic csi_sync_to_ext,
  clock_mode_if.partner link
);

  // Request sequencing states.
  typedef enum logic {ST_IDLE, ST_BUSY} req_state_e;

  req_state_e state_q; // Request state.
  logic write_q; // Latched direction.
  logic [7:0] addr_q; // Latched offset.
  logic [7:0] wdata_q; // Latched write data.
  logic rsp_q; // Response pulse.
  logic [7:0] rdata_q; // Response data.
  logic [31:0] grant_q; // Capped throughput.
  logic own_ref_q; // Sensor reference supplied locally.
  logic ext_mode; // Device wants the external reference.

  assign ext_mode = (link.active_mode == clock_mode_pkg::MODE_EXT)
                    || (link.active_mode == clock_mode_pkg::MODE_PVC);

  // One request at a time; held until the device acknowledges it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      write_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      rsp_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      rsp_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cmd_valid) begin
            write_q <= cmd_write;
            addr_q <= cmd_addr;
            wdata_q <= cmd_wdata;
            state_q <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (link.reg_ack) begin
            rsp_q <= 1'b1;
            rdata_q <= link.reg_rdata;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Throughput cap and sensor reference choice follow the device's mode.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      grant_q <= 32'h0000_0000;
      own_ref_q <= 1'b0;
    end else begin
      grant_q <= (csi_request_khz > link.csi_limit_khz) ? link.csi_limit_khz
                                                        : csi_request_khz;
      own_ref_q <= (link.active_mode == clock_mode_pkg::MODE_INT);
    end
  end

  assign cmd_ready = (state_q == ST_IDLE);
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign link.reg_valid = (state_q == ST_BUSY);
  assign link.reg_write = write_q;
  assign link.reg_addr = addr_q;
  assign link.reg_wdata = wdata_q;
  assign link.backchannel_ref_khz = recovered_ref_khz;
  assign link.external_reference_input_khz = ext_mode ? local_ref_khz : 32'h0000_0000;
  assign csi_granted_khz = grant_q;
  assign sensor_own_ref_enable = own_ref_q;
  assign csi_sync_to_ext = (link.active_mode == clock_mode_pkg::MODE_PVC);

endmodule : clock_mode_partner

// ===== verif/clock_mode_properties.sv
// Concurrent checks on the link between the serializer end and its companion end.
`timescale 1ns/1ns
module clock_mode_properties #(
  parameter int RELOCK_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_valid,
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic reg_ack,
  input wire logic [7:0] reg_rdata,
  input wire logic [31:0] backchannel_ref_khz,
  input wire logic [31:0] external_reference_input_khz,
  input wire logic [2:0] active_mode,
  input wire logic link_locked,
  input wire logic [31:0] forward_line_rate_khz,
  input wire logic [31:0] csi_limit_khz
);
  logic [15:0] low_cnt_q; // Cycles spent out of lock since the last lock or reset.

  // Count unlocked cycles so the relock length can be judged on the rising lock.
  always_ff @(posedge clk) begin
    if (!rst_n || link_locked) begin
      low_cnt_q <= 16'h0000;
    end else begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Rates are only judged while locked on both cycles, because a mode switch relocks first.
  property p_ack_pulse;
    reg_ack |=> !reg_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_next;
    reg_valid && !reg_ack |=> reg_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not acknowledged");
  property p_mode_read;
    reg_valid && !reg_ack && !reg_write && reg_addr == clock_mode_pkg::ADDR_MODE
      |=> reg_rdata[2:0] == $past(active_mode);
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode field differs");
  property p_sync_rate;
    link_locked && active_mode == clock_mode_pkg::MODE_SYNC ##1 link_locked
      |-> forward_line_rate_khz == $past(backchannel_ref_khz) * 32'd160;
  endproperty
  a_sync_rate: assert property (p_sync_rate) else $error("sync line rate wrong");
  property p_ext_rate;
    link_locked && active_mode == clock_mode_pkg::MODE_EXT ##1 link_locked
      |-> forward_line_rate_khz == $past(external_reference_input_khz) * 32'd80
      || forward_line_rate_khz == $past(external_reference_input_khz) * 32'd40;
  endproperty
  a_ext_rate: assert property (p_ext_rate) else $error("external line rate wrong");
  property p_int_rate;
    link_locked && active_mode == clock_mode_pkg::MODE_INT ##1 link_locked
      |-> forward_line_rate_khz inside {32'd4000000, 32'd2000000};
  endproperty
  a_int_rate: assert property (p_int_rate) else $error("internal line rate wrong");
  property p_pvc_rate;
    link_locked && active_mode == clock_mode_pkg::MODE_PVC ##1 link_locked
      |-> forward_line_rate_khz == $past(external_reference_input_khz) * 32'd28
      && (csi_limit_khz == $past(external_reference_input_khz) * 32'd20
      || csi_limit_khz == $past(external_reference_input_khz) * 32'd18);
  endproperty
  a_pvc_rate: assert property (p_pvc_rate) else $error("compat rates wrong");
  property p_csi_ratio;
    link_locked ##1 link_locked && active_mode != clock_mode_pkg::MODE_PVC
      |-> csi_limit_khz * 32'd5 == forward_line_rate_khz * 32'd4;
  endproperty
  a_csi_ratio: assert property (p_csi_ratio) else $error("bandwidth limit ratio wrong");
  property p_mode_relock;
    $changed(active_mode) |-> !link_locked;
  endproperty
  a_mode_relock: assert property (p_mode_relock) else $error("mode changed while locked");
  property p_relock_len;
    $rose(link_locked) |-> int'(low_cnt_q) >= RELOCK_CYCLES;
  endproperty
  a_relock_len: assert property (p_relock_len) else $error("relock too short");
endmodule : clock_mode_properties

// ===== verif/serializer_clock_mode_select_test.sv
// Self-checking bench joining the serializer end and its companion end.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module serializer_clock_mode_select_test;
  localparam int RELOCK = 4; // Short relock keeps the run brief.
  logic clk = 1'b0, rst_n = 1'b0, power_down_release = 1'b0, frame_active = 1'b0;
  logic pkt_valid = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0;
  logic [2:0] strap_mode = 3'h5; // Strap selects the parallel compatibility mode.
  logic [5:0] pkt_dt = 6'h00;
  logic [7:0] cmd_addr = 8'h00, cmd_wdata = 8'h00, rsp_rdata, parallel_video_config;
  logic [31:0] local_ref_khz = 32'd25000, recovered_ref_khz = 32'd25000;
  logic [31:0] csi_request_khz = 32'd0, csi_granted_khz, sensor_clock_khz;
  logic pkt_pass, csi_sync_to_ref, sensor_clock_enable, raw12_select, cmd_ready, rsp_valid;
  logic sensor_own_ref_enable, csi_sync_to_ext;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  logic [15:0] rst_tab [8] = '{16'h0300, 16'h0400, 16'h0500, 16'h0608, 16'h0701,
    16'h1000, 16'h1100, 16'h2000}; // Offset and reset value; 0x20 is unmapped.

  clock_mode_if u_clock_mode_if ();
  serializer_clock_mode_select #(.RELOCK_CYCLES(RELOCK)) u_serializer_clock_mode_select (
    .clk(clk), .rst_n(rst_n), .power_down_release(power_down_release),
    .strap_mode(strap_mode), .frame_active(frame_active), .pkt_valid(pkt_valid),
    .pkt_dt(pkt_dt), .pkt_pass(pkt_pass), .csi_sync_to_ref(csi_sync_to_ref),
    .sensor_clock_enable(sensor_clock_enable), .sensor_clock_khz(sensor_clock_khz),
    .parallel_video_config(parallel_video_config), .raw12_select(raw12_select),
    .link(u_clock_mode_if));
  clock_mode_partner u_clock_mode_partner (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .local_ref_khz(local_ref_khz), .recovered_ref_khz(recovered_ref_khz),
    .csi_request_khz(csi_request_khz), .csi_granted_khz(csi_granted_khz),
    .sensor_own_ref_enable(sensor_own_ref_enable), .csi_sync_to_ext(csi_sync_to_ext),
    .link(u_clock_mode_if));
  clock_mode_properties #(.RELOCK_CYCLES(RELOCK)) u_clock_mode_properties (.clk(clk),
    .rst_n(rst_n), .reg_valid(u_clock_mode_if.reg_valid),
    .reg_write(u_clock_mode_if.reg_write), .reg_addr(u_clock_mode_if.reg_addr),
    .reg_ack(u_clock_mode_if.reg_ack), .reg_rdata(u_clock_mode_if.reg_rdata),
    .backchannel_ref_khz(u_clock_mode_if.backchannel_ref_khz),
    .external_reference_input_khz(u_clock_mode_if.external_reference_input_khz),
    .active_mode(u_clock_mode_if.active_mode), .link_locked(u_clock_mode_if.link_locked),
    .forward_line_rate_khz(u_clock_mode_if.forward_line_rate_khz),
    .csi_limit_khz(u_clock_mode_if.csi_limit_khz));

  // Clock of 4 ns period.
  always #2 clk = ~clk;

  // Cut a hang short well above the expected run of about 340 cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      conclude();
    end
  end

  // One request through the companion end; entered and left 1 ns after an edge.
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] rd);
    int n;
    n = 0;
    `CHK("ready", 1'b1, cmd_ready)
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = d;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 20);
    rd = rsp_rdata;
    `CHK("response", 1'b1, rsp_valid)
  endtask : access

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    access(1'b1, a, d, r);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    access(1'b0, a, 8'h00, r);
    `CHK("register", e, r)
  endtask : rchk

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles

  // Offer one packet header and check the filter verdict a cycle later.
  // Valid stays up between headers, so it is never lowered and raised in one time step.
  task automatic pkt(input logic [5:0] dt, input logic e);
    pkt_valid = 1'b1;
    pkt_dt = dt;
    cycles(1);
    `CHK("pkt_pass", e, pkt_pass)
  endtask : pkt

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // Main sequence: reset values, strap capture, override, then every clocking mode.
  initial begin
    cycles(8);
    rst_n = 1'b1;
    foreach (rst_tab[i]) rchk(rst_tab[i][15:8], rst_tab[i][7:0]);
    power_down_release = 1'b1;
    cycles(RELOCK + 8);
    rchk(8'h03, 8'h05);
    `CHK("line", 32'd700000, u_clock_mode_if.forward_line_rate_khz)
    `CHK("csi", 32'd500000, u_clock_mode_if.csi_limit_khz)
    `CHK("sync_ext", 1'b1, csi_sync_to_ext)
    wr(8'h04, 8'h01);
    cycles(2);
    `CHK("csi", 32'd450000, u_clock_mode_if.csi_limit_khz)
    `CHK("raw12", 1'b1, raw12_select)
    wr(8'h03, 8'h02);
    rchk(8'h03, 8'h05);
    wr(8'h03, 8'h10);
    rchk(8'h03, 8'h15);
    frame_active = 1'b1;
    wr(8'h03, 8'h13);
    cycles(RELOCK + 8);
    `CHK("mode", 3'h5, u_clock_mode_if.active_mode)
    frame_active = 1'b0;
    cycles(RELOCK + 8);
    rchk(8'h03, 8'h13);
    `CHK("sclk_en", 1'b0, sensor_clock_enable)
    `CHK("sclk", 32'd0, sensor_clock_khz)
    `CHK("sync_ref", 1'b0, csi_sync_to_ref)
    `CHK("line", 32'd2000000, u_clock_mode_if.forward_line_rate_khz)
    `CHK("own_ref", 1'b1, sensor_own_ref_enable)
    `CHK("ext_ref", 32'd0, u_clock_mode_if.external_reference_input_khz)
    wr(8'h05, 8'h08);
    cycles(2);
    `CHK("line", 32'd4000000, u_clock_mode_if.forward_line_rate_khz)
    wr(8'h05, 8'h01);
    wr(8'h03, 8'h12);
    cycles(RELOCK + 8);
    `CHK("line", 32'd1000000, u_clock_mode_if.forward_line_rate_khz)
    `CHK("csi", 32'd800000, u_clock_mode_if.csi_limit_khz)
    `CHK("sync_ref", 1'b1, csi_sync_to_ref)
    wr(8'h05, 8'h00);
    cycles(100);
    `CHK("line", 32'd2000000, u_clock_mode_if.forward_line_rate_khz)
    `CHK("sclk", 32'd500000, sensor_clock_khz)
    wr(8'h06, 8'h0A);
    wr(8'h03, 8'h10);
    cycles(100);
    `CHK("line", 32'd4000000, u_clock_mode_if.forward_line_rate_khz)
    `CHK("csi", 32'd3200000, u_clock_mode_if.csi_limit_khz)
    `CHK("sclk", 32'd250000, sensor_clock_khz)
    `CHK("sclk_en", 1'b1, sensor_clock_enable)
    csi_request_khz = 32'd5000000;
    cycles(2);
    `CHK("granted", 32'd3200000, csi_granted_khz)
    wr(8'h11, 8'h2B);
    wr(8'h10, 8'h80);
    `CHK("pv_cfg", 8'h80, parallel_video_config)
    pkt(6'h2B, 1'b1);
    pkt(6'h2C, 1'b0);
    wr(8'h10, 8'h00);
    pkt(6'h2B, 1'b0);
    conclude();
  end
endmodule : serializer_clock_mode_select_test
